// [design/power_state_pkg.sv]
// Shared constants and types for the processor low-power state and management-mode controller
package power_state_pkg;

	// ****************************************************************
	// Sequencer states
	// ****************************************************************
	typedef enum logic [2:0] {
		ST_RUN,
		ST_HALT_ACK,
		ST_HALT,
		ST_SLEEP,
		ST_SMM_ACK,
		ST_SMM
	} pstate_e;

	// ****************************************************************
	// Acknowledge transaction codes and widths
	// ****************************************************************
	localparam int          ACK_W        = 2;
	localparam logic [1:0]  ACK_NONE     = 2'h0;
	localparam logic [1:0]  ACK_HALT     = 2'h1;
	localparam logic [1:0]  ACK_SMM      = 2'h2;

	// ****************************************************************
	// Synchroniser layout and reset values
	// ****************************************************************
	localparam int          SYNC_BITS    = 3;
	localparam int          BIT_HALT     = 0;
	localparam int          BIT_SLEEP    = 1;
	localparam int          BIT_SMI      = 2;
	localparam logic [2:0]  SYNC_RESET   = 3'h7;

	// Bus outputs must be released within this many bus clocks of reset
	localparam int          RESET_RELEASE_CLKS = 2;

endpackage : power_state_pkg

// [design/power_state_ctrl.sv]
// Low-power clock state sequencer with management-mode entry and reset-time output float
`timescale 1ns/1ns

module power_state_ctrl (
	input  wire logic                               sys_clk,
	input  wire logic                               rst,
	input  wire logic                               clk_en,
	input  wire logic                               clock_halt_request_n,
	input  wire logic                               deep_sleep_request_n,
	input  wire logic                               sys_mgmt_interrupt_n,
	input  wire logic                               bus_clock_present,
	input  wire logic                               snoop_req,
	input  wire logic                               intr_req,
	input  wire logic                               ack_ready,
	input  wire logic                               smm_resume,
	output logic                                    ack_valid,
	output logic [power_state_pkg::ACK_W-1:0]       ack_code,
	output logic                                    snoop_ack,
	output logic                                    intr_taken,
	output logic                                    state_save,
	output logic                                    handler_start,
	output logic                                    smm_active,
	output logic                                    exec_run,
	output logic                                    core_clk_en,
	output logic                                    bus_unit_clk_en,
	output logic                                    intc_clk_en,
	output logic                                    pll_run,
	output logic                                    bus_drive_en
);

	// ****************************************************************
	// Input synchronisers
	// ****************************************************************
	logic [power_state_pkg::SYNC_BITS-1:0] sync_meta;
	logic [power_state_pkg::SYNC_BITS-1:0] sync_out;
	logic [power_state_pkg::SYNC_BITS-1:0] raw_n;

	assign raw_n = {sys_mgmt_interrupt_n, deep_sleep_request_n, clock_halt_request_n};

	// The bus clock is gated only in sleep, never in clock-halt; the halt request only moves the sequencer
	genvar gi;
	generate
		for (gi = 0; gi < power_state_pkg::SYNC_BITS; gi++) begin : g_sync
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					sync_meta[gi] <= power_state_pkg::SYNC_RESET[gi];
					sync_out[gi]  <= power_state_pkg::SYNC_RESET[gi];
				end else if (clk_en) begin
					sync_meta[gi] <= raw_n[gi];
					sync_out[gi]  <= sync_meta[gi];
				end
			end
		end
	endgenerate

	logic halt_req;
	logic sleep_req;
	logic smi_req;
	assign halt_req  = !sync_out[power_state_pkg::BIT_HALT];
	assign sleep_req = !sync_out[power_state_pkg::BIT_SLEEP];
	assign smi_req   = !sync_out[power_state_pkg::BIT_SMI];

	// ****************************************************************
	// Reset-release strap and output float
	// ****************************************************************
	logic strap_done;
	logic float_out;
	logic next_strap_done;
	logic next_float_out;

	// Raw pin caught on the first enabled edge after release, not through the synchroniser,
	// so the float decision does not wait two cycles
	always_comb begin
		next_strap_done = 1'b1;
		next_float_out  = float_out;
		if (!strap_done) begin
			next_float_out = !sys_mgmt_interrupt_n;
		end
	end

	// Async reset clears drive enable at once, well inside the release limit
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			strap_done <= 1'b0;
			float_out  <= 1'b0;
		end else if (clk_en) begin
			strap_done <= next_strap_done;
			float_out  <= next_float_out;
		end
	end

	// ****************************************************************
	// Management interrupt pending latch
	// ****************************************************************
	logic smi_prev;
	logic smi_pend;
	logic next_smi_prev;
	logic next_smi_pend;
	logic smi_accept;

	power_state_pkg::pstate_e state;
	power_state_pkg::pstate_e next_state;

	always_comb begin
		next_smi_prev = smi_req;
		next_smi_pend = smi_pend;
		if (smi_accept) begin
			next_smi_pend = 1'b0;
		end
		// Edge arriving with the clear still wins; ignored entirely while asleep
		if (smi_req && !smi_prev && state != power_state_pkg::ST_SLEEP) begin
			next_smi_pend = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			smi_prev <= 1'b0;
			smi_pend <= 1'b0;
		end else if (clk_en) begin
			smi_prev <= next_smi_prev;
			smi_pend <= next_smi_pend;
		end
	end

	// ****************************************************************
	// State sequencer
	// ****************************************************************
	logic active;
	assign active = strap_done && !float_out;
	assign smi_accept = active && smi_pend &&
		(state == power_state_pkg::ST_RUN || state == power_state_pkg::ST_HALT);

	logic                              next_core_clk;
	logic                              next_bus_clk;
	logic [power_state_pkg::ACK_W-1:0] next_ack_code;
	logic                              next_snoop_ack;
	logic                              next_intr_taken;
	logic                              next_state_save;
	logic                              next_handler_start;

	always_comb begin
		next_state         = state;
		next_state_save    = 1'b0;
		next_handler_start = 1'b0;
		unique case (state)
			power_state_pkg::ST_RUN: begin
				if (smi_accept) begin
					next_state      = power_state_pkg::ST_SMM_ACK;
					next_state_save = 1'b1;
				end else if (active && halt_req) begin
					next_state = power_state_pkg::ST_HALT_ACK;
				end
			end
			power_state_pkg::ST_HALT_ACK: begin
				if (ack_ready) begin
					next_state = power_state_pkg::ST_HALT;
				end
			end
			power_state_pkg::ST_HALT: begin
				if (smi_accept) begin
					next_state      = power_state_pkg::ST_SMM_ACK;
					next_state_save = 1'b1;
				end else if (!halt_req) begin
					next_state = power_state_pkg::ST_RUN;
				end else if (sleep_req) begin
					next_state = power_state_pkg::ST_SLEEP;
				end
			end
			power_state_pkg::ST_SLEEP: begin
				// Only sleep removal leaves; reset acts asynchronously
				if (!sleep_req) begin
					next_state = power_state_pkg::ST_HALT;
				end
			end
			power_state_pkg::ST_SMM_ACK: begin
				if (ack_ready) begin
					next_state         = power_state_pkg::ST_SMM;
					next_handler_start = 1'b1;
				end
			end
			power_state_pkg::ST_SMM: begin
				if (smm_resume) begin
					next_state = power_state_pkg::ST_RUN;
				end
			end
			default: begin
				next_state = power_state_pkg::ST_RUN;
			end
		endcase
		// Sleep outside clock-halt never reaches the sequencer
		next_core_clk = !(next_state == power_state_pkg::ST_HALT ||
			next_state == power_state_pkg::ST_SLEEP);
		next_bus_clk  = next_state != power_state_pkg::ST_SLEEP;
		next_ack_code = power_state_pkg::ACK_NONE;
		if (next_state == power_state_pkg::ST_HALT_ACK) begin
			next_ack_code = power_state_pkg::ACK_HALT;
		end else if (next_state == power_state_pkg::ST_SMM_ACK) begin
			next_ack_code = power_state_pkg::ACK_SMM;
		end
		next_snoop_ack  = active && snoop_req && state != power_state_pkg::ST_SLEEP;
		next_intr_taken = active && intr_req && state != power_state_pkg::ST_SLEEP;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state           <= power_state_pkg::ST_RUN;
			core_clk_en     <= 1'b1;
			bus_unit_clk_en <= 1'b1;
			intc_clk_en     <= 1'b1;
			ack_code        <= power_state_pkg::ACK_NONE;
			snoop_ack       <= 1'b0;
			intr_taken      <= 1'b0;
			state_save      <= 1'b0;
			handler_start   <= 1'b0;
		end else if (clk_en) begin
			state           <= next_state;
			core_clk_en     <= next_core_clk;
			bus_unit_clk_en <= next_bus_clk;
			intc_clk_en     <= next_bus_clk;
			ack_code        <= next_ack_code;
			snoop_ack       <= next_snoop_ack;
			intr_taken      <= next_intr_taken;
			state_save      <= next_state_save;
			handler_start   <= next_handler_start;
		end
	end

	// Acknowledge handshake is combinational; it holds until ack_ready is seen
	assign ack_valid    = active && (state == power_state_pkg::ST_HALT_ACK ||
		state == power_state_pkg::ST_SMM_ACK);
	assign bus_drive_en = active;
	assign smm_active   = state == power_state_pkg::ST_SMM;
	assign exec_run     = state == power_state_pkg::ST_RUN || state == power_state_pkg::ST_SMM;
	// PLL stays up in sleep; stops only once the bus clock is withdrawn there
	assign pll_run      = !(state == power_state_pkg::ST_SLEEP && !bus_clock_present);

	// ****************************************************************
	// Assertions
	// ****************************************************************
	AST_HALT_ENTRY: assert property (@(posedge sys_clk) disable iff (rst)
		clk_en && state == power_state_pkg::ST_RUN && active && halt_req && !smi_pend
		|=> state == power_state_pkg::ST_HALT_ACK && ack_valid && ack_code == power_state_pkg::ACK_HALT)
		else $error("halt request did not raise halt acknowledge");
	AST_HALT_CLOCKS: assert property (@(posedge sys_clk) disable iff (rst)
		state == power_state_pkg::ST_HALT |-> !core_clk_en && bus_unit_clk_en && intc_clk_en)
		else $error("wrong clock gating in clock-halt");
	AST_HALT_SNOOP: assert property (@(posedge sys_clk) disable iff (rst)
		clk_en && state == power_state_pkg::ST_HALT && active && snoop_req |=> snoop_ack)
		else $error("snoop not answered in clock-halt");
	AST_HALT_RESUME: assert property (@(posedge sys_clk) disable iff (rst)
		clk_en && state == power_state_pkg::ST_HALT && !halt_req && !smi_accept
		|=> state == power_state_pkg::ST_RUN && core_clk_en && exec_run)
		else $error("halt removal did not resume execution");
	AST_SLEEP_ONLY_FROM_HALT: assert property (@(posedge sys_clk) disable iff (rst)
		clk_en && state != power_state_pkg::ST_HALT && state != power_state_pkg::ST_SLEEP
		|=> state != power_state_pkg::ST_SLEEP)
		else $error("sleep entered from outside clock-halt");
	AST_SLEEP_CLOCKS: assert property (@(posedge sys_clk) disable iff (rst)
		state == power_state_pkg::ST_SLEEP |-> !core_clk_en && !bus_unit_clk_en && !intc_clk_en)
		else $error("unit clock running in sleep");
	AST_SLEEP_DEAF: assert property (@(posedge sys_clk) disable iff (rst)
		clk_en && state == power_state_pkg::ST_SLEEP |=> !snoop_ack && !intr_taken)
		else $error("snoop or interrupt answered in sleep");
	AST_SLEEP_EXIT: assert property (@(posedge sys_clk) disable iff (rst)
		clk_en && state == power_state_pkg::ST_SLEEP && !sleep_req
		|=> state == power_state_pkg::ST_HALT && bus_unit_clk_en)
		else $error("sleep removal did not return to clock-halt");
	AST_SMM_ENTRY: assert property (@(posedge sys_clk) disable iff (rst)
		clk_en && state == power_state_pkg::ST_SMM_ACK && ack_ready
		|=> smm_active && handler_start && $past(ack_code) == power_state_pkg::ACK_SMM)
		else $error("management entry sequence broken");
	AST_FLOAT: assert property (@(posedge sys_clk) disable iff (rst)
		float_out |-> !bus_drive_en && !ack_valid)
		else $error("outputs driven while floating");

endmodule : power_state_ctrl

// [verification/chipset_model.sv]
// System logic model driving the halt, sleep and management pins and accepting acknowledges
`timescale 1ns/1ns

module chipset_model (
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic       want_halt,
	input  wire logic       want_sleep,
	input  wire logic       want_smi,
	input  wire logic       rogue_sleep,
	input  wire logic [3:0] ready_delay,
	input  wire logic       ack_valid,
	input  wire logic [1:0] ack_code,
	output logic            halt_n,
	output logic            sleep_n,
	output logic            smi_n,
	output logic            ack_ready
);
	logic       halt_seen;
	logic [3:0] cnt;

	// Sleep once the halt acknowledge was taken, or at any time under rogue_sleep; halt held while the legitimate sleep is on
	assign sleep_n = !((want_sleep && halt_seen) || rogue_sleep);
	// Only a legitimate sleep keeps halt asserted; a stray sleep must not raise halt
	assign halt_n  = !(want_halt || (want_sleep && halt_seen));
	assign smi_n   = !want_smi;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			halt_seen <= 1'b0;
		else if (ack_valid && ack_ready && ack_code == power_state_pkg::ACK_HALT)
			halt_seen <= 1'b1;
		else if (!want_halt)
			halt_seen <= 1'b0;
	end

	// Ready is raised at the falling edge and held until the acknowledge drops
	always_ff @(negedge sys_clk or posedge rst) begin
		if (rst || !ack_valid) begin
			cnt       <= 4'h0;
			ack_ready <= 1'b0;
		end else begin
			cnt       <= cnt + 4'h1;
			ack_ready <= (cnt >= ready_delay);
		end
	end
endmodule : chipset_model

// [verification/tb.sv]
// Self-checking bench for the low-power state and management-mode controller
`timescale 1ns/1ns

module tb;
	logic       sys_clk = 1'b0, rst = 1'b1, clk_en = 1'b1;
	logic       bus_clock_present = 1'b1, snoop_req = 1'b0, intr_req = 1'b0;
	logic       smm_resume = 1'b0, want_halt = 1'b0, want_sleep = 1'b0;
	logic       want_smi = 1'b0, rogue_sleep = 1'b0;
	logic [3:0] ready_delay = 4'h0;
	logic       halt_n, sleep_n, smi_n, ack_ready, ack_valid, snoop_ack, intr_taken;
	logic       state_save, handler_start, smm_active, exec_run, core_clk_en;
	logic       bus_unit_clk_en, intc_clk_en, pll_run, bus_drive_en;
	logic [1:0] ack_code;
	int         mismatches = 0, check_count = 0, i;

	chipset_model partner (.sys_clk(sys_clk), .rst(rst), .want_halt(want_halt),
		.want_sleep(want_sleep), .want_smi(want_smi), .rogue_sleep(rogue_sleep),
		.ready_delay(ready_delay), .ack_valid(ack_valid), .ack_code(ack_code),
		.halt_n(halt_n), .sleep_n(sleep_n), .smi_n(smi_n), .ack_ready(ack_ready));

	power_state_ctrl uut (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
		.clock_halt_request_n(halt_n), .deep_sleep_request_n(sleep_n),
		.sys_mgmt_interrupt_n(smi_n), .bus_clock_present(bus_clock_present),
		.snoop_req(snoop_req), .intr_req(intr_req), .ack_ready(ack_ready),
		.smm_resume(smm_resume), .ack_valid(ack_valid), .ack_code(ack_code),
		.snoop_ack(snoop_ack), .intr_taken(intr_taken), .state_save(state_save),
		.handler_start(handler_start), .smm_active(smm_active), .exec_run(exec_run),
		.core_clk_en(core_clk_en), .bus_unit_clk_en(bus_unit_clk_en),
		.intc_clk_en(intc_clk_en), .pll_run(pll_run), .bus_drive_en(bus_drive_en));

	initial begin
		forever #25 sys_clk = ~sys_clk;
	end

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task wrap_up;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : wrap_up

	task probe(input logic exp);
		snoop_req = 1'b1;
		intr_req  = 1'b1;
		@(negedge sys_clk);
		snoop_req = 1'b0;
		intr_req  = 1'b0;
		check("snoop_ack", snoop_ack, exp);
		check("intr_taken", intr_taken, exp);
		@(negedge sys_clk);
		check("snoop_ack_end", snoop_ack, 1'b0);
	endtask : probe

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task do_reset(input logic smi);
		rst      = 1'b1;
		want_smi = smi;
		repeat (2) @(negedge sys_clk);
		check("drive_in_rst", bus_drive_en, 1'b0);
		check("core_in_rst", core_clk_en, 1'b1);
		rst = 1'b0;
		repeat (2) @(negedge sys_clk);
		check("drive_after", bus_drive_en, !smi);
		want_smi = 1'b0;
		repeat (4) @(negedge sys_clk);
		check("still_float", bus_drive_en, !smi);
	endtask : do_reset

	task halt_enter;
		want_halt = 1'b1;
		repeat (2) @(negedge sys_clk);
		check("early_ack", ack_valid, 1'b0);
		for (i = 0; i < 20 && ack_valid !== 1'b1; i++) @(negedge sys_clk);
		check("halt_code", ack_code, power_state_pkg::ACK_HALT);
		for (i = 0; i < 20 && core_clk_en !== 1'b0; i++) @(negedge sys_clk);
		check("core_clk", core_clk_en, 1'b0);
		check("bus_clk", bus_unit_clk_en, 1'b1);
		check("intc_clk", intc_clk_en, 1'b1);
		check("pll", pll_run, 1'b1);
		check("exec_halt", exec_run, 1'b0);
		probe(1'b1);
	endtask : halt_enter

	task sleep_cycle;
		want_sleep = 1'b1;
		for (i = 0; i < 20 && bus_unit_clk_en !== 1'b0; i++) @(negedge sys_clk);
		check("intc_sleep", intc_clk_en, 1'b0);
		check("pll_sleep", pll_run, 1'b1);
		probe(1'b0);
		bus_clock_present = 1'b0;
		#1;
		check("pll_no_bclk", pll_run, 1'b0);
		@(negedge sys_clk);
		bus_clock_present = 1'b1;
		want_sleep        = 1'b0;
		for (i = 0; i < 20 && bus_unit_clk_en !== 1'b1; i++) @(negedge sys_clk);
		check("core_wake", core_clk_en, 1'b0);
		check("intc_wake", intc_clk_en, 1'b1);
		want_halt = 1'b0;
		for (i = 0; i < 20 && core_clk_en !== 1'b1; i++) @(negedge sys_clk);
		check("resume", exec_run, 1'b1);
	endtask : sleep_cycle

	task stray_sleep;
		rogue_sleep = 1'b1;
		repeat (6) @(negedge sys_clk);
		check("exec_stray", exec_run, 1'b1);
		check("bus_stray", bus_unit_clk_en, 1'b1);
		rogue_sleep = 1'b0;
		repeat (4) @(negedge sys_clk);
	endtask : stray_sleep

	task smi_entry;
		ready_delay = 4'h3;
		want_smi    = 1'b1;
		for (i = 0; i < 20 && state_save !== 1'b1; i++) @(negedge sys_clk);
		check("save", state_save, 1'b1);
		check("smm_code", ack_code, power_state_pkg::ACK_SMM);
		for (i = 0; i < 20 && handler_start !== 1'b1; i++) @(negedge sys_clk);
		check("ack_done", ack_valid, 1'b0);
		check("smm_on", smm_active, 1'b1);
		check("handler", handler_start, 1'b1);
		check("save_pulse", state_save, 1'b0);
		want_smi   = 1'b0;
		smm_resume = 1'b1;
		@(negedge sys_clk);
		smm_resume = 1'b0;
		check("handler_pulse", handler_start, 1'b0);
		repeat (2) @(negedge sys_clk);
		check("smm_off", smm_active, 1'b0);
	endtask : smi_entry

	// A low clock enable must hold the synchronisers and the sequencer still
	task freeze_hold;
		clk_en    = 1'b0;
		want_halt = 1'b1;
		repeat (5) @(negedge sys_clk);
		check("frozen_ack", ack_valid, 1'b0);
		check("frozen_core", core_clk_en, 1'b1);
		want_halt = 1'b0;
		clk_en    = 1'b1;
		repeat (4) @(negedge sys_clk);
		check("frozen_exec", exec_run, 1'b1);
	endtask : freeze_hold

	// Hang guard sized well past the sum of all bounded waits
	initial begin
		#(50 * 4000);
		mismatches++;
		wrap_up();
	end

	initial begin
		do_reset(1'b0);
		halt_enter();
		sleep_cycle();
		stray_sleep();
		smi_entry();
		do_reset(1'b1);
		do_reset(1'b0);
		freeze_hold();
		wrap_up();
	end
endmodule : tb
